/* File: lnk_pkg.sv */
package lnk_pkg;
    // register offsets on the host port
    localparam logic [7:0] OFF_DIAG = 8'h20;
    localparam logic [7:0] OFF_PHY = 8'h24;
    localparam logic [7:0] OFF_TXQ_STAT = 8'h30;
    localparam logic [7:0] OFF_RAM_WIN = 8'h80;
    localparam logic [7:0] OFF_TXQ_FIRST = 8'ha0;
    localparam logic [7:0] OFF_TXQ_NEXT = 8'ha4;

    // reset values
    localparam logic [31:0] DIAG_RST = 32'h0000_0000;
    localparam logic [31:0] PHY_RST = 32'h0000_0000;
    localparam logic [31:0] TXQ_STAT_RST = 32'h0000_0000;

    // diagnostic control fields
    localparam int DIAG_SNOOP_BIT = 0;
    localparam int DIAG_UNLOCK_BIT = 4;

    // phy mailbox fields
    localparam int PHY_RD_BIT = 0;
    localparam int PHY_WR_BIT = 1;
    localparam int PHY_TADDR_LSB = 4;
    localparam int PHY_WVAL_LSB = 8;
    localparam int PHY_RADDR_LSB = 20;
    localparam int PHY_RVAL_LSB = 24;
    // reserved bits 2-3 and 16-19 are not stored
    localparam logic [31:0] PHY_WMASK = 32'hfff0_fff3;

    // async transmit queue status fields
    localparam int TXQ_FULL_BIT = 0;
    localparam int TXQ_EMPTY_BIT = 1;
    localparam int TXQ_TAGERR_BIT = 2;
    localparam int TXQ_PCLR_BIT = 3;
    localparam int TXQ_TAG_BIT = 4;
    localparam int TXQ_TEST_BIT = 5;
    localparam int TXQ_PTR_LSB = 6;
    localparam int TXQ_SPACE_LSB = 23;

    // queue memory geometry
    localparam int QW = 33;
    localparam int RAM_AW = 9;
    localparam int RAM_DEPTH = 512;
    localparam int TXQ_AW = 8;
    localparam logic [8:0] TXQ_DEPTH = 9'h100;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } lnk_host_req_t;

    typedef struct packed {
        logic wr;
        logic [3:0] addr;
        logic [7:0] data;
    } lnk_phy_req_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
    } lnk_phy_reply_t;

    typedef enum logic [1:0] {
        PHY_IDLE = 2'b01,
        PHY_SEND = 2'b10
    } lnk_phy_state_t;
endpackage

/* File: lnk_queue_ram.sv */
`timescale 1ns/100ps
module lnk_queue_ram
    import lnk_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_we,
    input wire logic [RAM_AW-1:0] i_waddr,
    input wire logic [QW-1:0] i_wdata,
    input wire logic i_re,
    input wire logic [RAM_AW-1:0] i_raddr,
    output logic [QW-1:0] o_rdata
);
    logic [QW-1:0] mem [RAM_DEPTH];

    // contents are not reset; ram test exists to check them
    always_ff @(posedge i_mclk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_re) begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

/* File: lnk_diag_regs.sv */
`timescale 1ns/100ps
module lnk_diag_regs
    import lnk_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire lnk_host_req_t i_host,
    output logic o_rvalid,
    output logic [31:0] o_rdata,
    output logic o_snoop_enable,
    output logic o_phy_req,
    output lnk_phy_req_t o_phy_cmd,
    input wire logic i_phy_ack,
    input wire logic i_phy_reply_valid,
    input wire lnk_phy_reply_t i_phy_reply,
    output logic o_phy_reply_irq,
    input wire logic i_tx_take,
    output logic o_tx_valid,
    output logic [QW-1:0] o_tx_word
);
    function automatic logic hit(input lnk_host_req_t r,
                                 input logic [7:0] off);
        return r.addr == off;
    endfunction

    function automatic logic [RAM_AW-1:0] ram_addr(input logic clr,
                                   input logic [RAM_AW-1:0] p);
        return clr ? '0 : p;
    endfunction

    logic [31:0] diag_q;
    logic [31:0] phy_q;
    lnk_phy_state_t phy_state_q;
    logic pclr_q;
    logic tag_q;
    logic ram_test_q;
    logic tagerr_q;
    logic [RAM_AW-1:0] ptr_q;
    logic [TXQ_AW-1:0] wr_ptr_q;
    logic [TXQ_AW-1:0] rd_ptr_q;
    logic [8:0] count_q;
    logic fetch_q;
    logic ram_cmp_q;
    logic rd_p1_q;
    logic rd_ram_p1_q;
    logic [31:0] rd_word_p1_q;
    logic o_rvalid_q;
    logic [31:0] o_rdata_q;
    logic o_phy_req_q;
    lnk_phy_req_t o_phy_cmd_q;
    logic o_phy_reply_irq_q;
    logic o_tx_valid_q;
    logic [QW-1:0] o_tx_word_q;

    logic wr_diag;
    logic wr_phy;
    logic wr_stat;
    logic wr_win;
    logic rd_win;
    logic wr_queue;
    logic full;
    logic empty;
    logic push;
    logic fetch;
    logic ram_acc;
    logic [RAM_AW-1:0] test_addr;
    logic ram_we;
    logic [RAM_AW-1:0] ram_waddr;
    logic [QW-1:0] ram_wdata;
    logic ram_re;
    logic [RAM_AW-1:0] ram_raddr;
    logic [QW-1:0] ram_rdata;
    logic [8:0] space;
    logic [31:0] stat_word;
    logic [31:0] rd_word;

    assign wr_diag = i_host.wr && hit(i_host, OFF_DIAG);
    assign wr_phy = i_host.wr && hit(i_host, OFF_PHY);
    assign wr_stat = i_host.wr && hit(i_host, OFF_TXQ_STAT);
    assign wr_win = i_host.wr && hit(i_host, OFF_RAM_WIN);
    assign rd_win = i_host.rd && hit(i_host, OFF_RAM_WIN);
    assign wr_queue = i_host.wr && (hit(i_host, OFF_TXQ_FIRST) ||
                                    hit(i_host, OFF_TXQ_NEXT));

    assign full = count_q == TXQ_DEPTH;
    assign empty = count_q == 9'h000;
    assign space = 9'(TXQ_DEPTH - count_q);

    assign push = wr_queue && !ram_test_q && !full;
    assign fetch = !ram_test_q && !empty && !o_tx_valid_q && !fetch_q;
    assign ram_acc = ram_test_q && (wr_win || rd_win);
    assign test_addr = ram_addr(pclr_q, ptr_q);

    always_comb begin
        ram_we = 1'b0;
        ram_waddr = {1'b0, wr_ptr_q};
        ram_wdata = {hit(i_host, OFF_TXQ_FIRST), i_host.wdata};
        ram_re = fetch;
        ram_raddr = {1'b0, rd_ptr_q};
        if (ram_test_q) begin
            ram_we = wr_win;
            ram_waddr = test_addr;
            ram_wdata = {tag_q, i_host.wdata};
            ram_re = rd_win;
            ram_raddr = test_addr;
        end else if (push) begin
            ram_we = 1'b1;
        end
    end

    lnk_queue_ram u_ram (
        .i_mclk(i_mclk),
        .i_we(ram_we),
        .i_waddr(ram_waddr),
        .i_wdata(ram_wdata),
        .i_re(ram_re),
        .i_raddr(ram_raddr),
        .o_rdata(ram_rdata)
    );

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            diag_q <= DIAG_RST;
        end else if (wr_diag) begin
            if (diag_q[DIAG_UNLOCK_BIT]) begin
                diag_q <= i_host.wdata;
            end else begin
                diag_q[DIAG_SNOOP_BIT] <= i_host.wdata[DIAG_SNOOP_BIT];
                diag_q[DIAG_UNLOCK_BIT] <= i_host.wdata[DIAG_UNLOCK_BIT];
            end
        end
    end

    assign o_snoop_enable = diag_q[DIAG_SNOOP_BIT];

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            phy_q <= PHY_RST;
        end else begin
            if (phy_state_q == PHY_SEND && i_phy_ack) begin
                if (o_phy_cmd_q.wr) begin
                    phy_q[PHY_WR_BIT] <= 1'b0;
                end else begin
                    phy_q[PHY_RD_BIT] <= 1'b0;
                end
            end
            // host write wins over the self-clear
            if (wr_phy) begin
                phy_q <= i_host.wdata & PHY_WMASK;
            end
            if (i_phy_reply_valid) begin
                phy_q[PHY_RADDR_LSB +: 4] <= i_phy_reply.addr;
                phy_q[PHY_RVAL_LSB +: 8] <= i_phy_reply.data;
            end
        end
    end

    // read has priority when both request bits are set
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            phy_state_q <= PHY_IDLE;
            o_phy_req_q <= 1'b0;
            o_phy_cmd_q <= '0;
        end else begin
            case (phy_state_q)
                PHY_IDLE: begin
                    if (phy_q[PHY_RD_BIT] || phy_q[PHY_WR_BIT]) begin
                        phy_state_q <= PHY_SEND;
                        o_phy_req_q <= 1'b1;
                        o_phy_cmd_q.wr <= !phy_q[PHY_RD_BIT];
                        o_phy_cmd_q.addr <= phy_q[PHY_TADDR_LSB +: 4];
                        o_phy_cmd_q.data <= phy_q[PHY_WVAL_LSB +: 8];
                    end
                end
                PHY_SEND: begin
                    if (i_phy_ack) begin
                        phy_state_q <= PHY_IDLE;
                        o_phy_req_q <= 1'b0;
                    end
                end
                default: begin
                    phy_state_q <= PHY_IDLE;
                    o_phy_req_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_phy_reply_irq_q <= 1'b0;
        end else begin
            o_phy_reply_irq_q <= i_phy_reply_valid;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pclr_q <= TXQ_STAT_RST[TXQ_PCLR_BIT];
            tag_q <= TXQ_STAT_RST[TXQ_TAG_BIT];
            ram_test_q <= TXQ_STAT_RST[TXQ_TEST_BIT];
        end else begin
            if (ram_acc) begin
                pclr_q <= 1'b0;
            end
            if (wr_stat) begin
                pclr_q <= i_host.wdata[TXQ_PCLR_BIT];
                tag_q <= i_host.wdata[TXQ_TAG_BIT];
                ram_test_q <= i_host.wdata[TXQ_TEST_BIT];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ptr_q <= TXQ_STAT_RST[TXQ_PTR_LSB +: RAM_AW];
        end else if (ram_acc) begin
            ptr_q <= RAM_AW'(test_addr + 9'h001);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            tagerr_q <= TXQ_STAT_RST[TXQ_TAGERR_BIT];
        end else begin
            if ((wr_stat && (i_host.wdata[TXQ_PCLR_BIT] ||
                             !i_host.wdata[TXQ_TEST_BIT])) ||
                (ram_acc && pclr_q)) begin
                tagerr_q <= 1'b0;
            end
            if (ram_cmp_q && (ram_rdata[QW-1] != tag_q)) begin
                tagerr_q <= 1'b1;
            end
        end
    end

    // count tracks words written but not yet fetched for transmit
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= TXQ_AW'(wr_ptr_q + 8'h01);
            end
            if (fetch) begin
                rd_ptr_q <= TXQ_AW'(rd_ptr_q + 8'h01);
            end
            if (push && !fetch) begin
                count_q <= 9'(count_q + 9'h001);
            end else if (fetch && !push) begin
                count_q <= 9'(count_q - 9'h001);
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            fetch_q <= 1'b0;
            o_tx_valid_q <= 1'b0;
            o_tx_word_q <= '0;
        end else begin
            fetch_q <= fetch;
            if (fetch_q) begin
                o_tx_valid_q <= 1'b1;
                o_tx_word_q <= ram_rdata;
            end else if (i_tx_take) begin
                o_tx_valid_q <= 1'b0;
            end
        end
    end

    always_comb begin
        stat_word = '0;
        stat_word[TXQ_FULL_BIT] = full;
        stat_word[TXQ_EMPTY_BIT] = empty;
        stat_word[TXQ_TAGERR_BIT] = tagerr_q;
        stat_word[TXQ_PCLR_BIT] = pclr_q;
        stat_word[TXQ_TAG_BIT] = tag_q;
        stat_word[TXQ_TEST_BIT] = ram_test_q;
        stat_word[TXQ_PTR_LSB +: RAM_AW] = ptr_q;
        stat_word[TXQ_SPACE_LSB +: 9] = space;
    end

    // unmapped offsets read as zero
    always_comb begin
        rd_word = '0;
        if (hit(i_host, OFF_DIAG)) begin
            rd_word = diag_q;
        end else if (hit(i_host, OFF_PHY)) begin
            rd_word = phy_q;
        end else if (hit(i_host, OFF_TXQ_STAT)) begin
            rd_word = stat_word;
        end
    end

    // every read answers two edges later so ram and registers line up
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rd_p1_q <= 1'b0;
            rd_ram_p1_q <= 1'b0;
            rd_word_p1_q <= '0;
            ram_cmp_q <= 1'b0;
            o_rvalid_q <= 1'b0;
            o_rdata_q <= '0;
        end else begin
            rd_p1_q <= i_host.rd;
            rd_ram_p1_q <= ram_acc && rd_win;
            ram_cmp_q <= ram_acc && rd_win;
            rd_word_p1_q <= rd_word;
            o_rvalid_q <= rd_p1_q;
            o_rdata_q <= rd_ram_p1_q ? ram_rdata[31:0] : rd_word_p1_q;
        end
    end

    assign o_rvalid = o_rvalid_q;
    assign o_rdata = o_rdata_q;
    assign o_phy_req = o_phy_req_q;
    assign o_phy_cmd = o_phy_cmd_q;
    assign o_phy_reply_irq = o_phy_reply_irq_q;
    assign o_tx_valid = o_tx_valid_q;
    assign o_tx_word = o_tx_word_q;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    AST_DIAG_LOCK: assert property (
        wr_diag && !diag_q[DIAG_UNLOCK_BIT] |=>
            diag_q[3:1] == $past(diag_q[3:1]) &&
            diag_q[31:5] == $past(diag_q[31:5]))
        else $error("locked diagnostic bit changed");

    AST_DIAG_RST: assert property (
        $past(i_rst) |-> diag_q == DIAG_RST)
        else $error("diagnostic register not zero after reset");

    AST_SNOOP: assert property (
        wr_diag |=> o_snoop_enable == $past(i_host.wdata[DIAG_SNOOP_BIT]))
        else $error("snoop enable did not follow write");

    AST_PHY_RD: assert property (
        phy_state_q == PHY_IDLE && phy_q[PHY_RD_BIT] |=>
            o_phy_req && !o_phy_cmd.wr &&
            o_phy_cmd.addr == $past(phy_q[7:4]))
        else $error("phy read request not issued");

    AST_PHY_WR: assert property (
        phy_state_q == PHY_IDLE && phy_q[PHY_WR_BIT] &&
        !phy_q[PHY_RD_BIT] |=> o_phy_req && o_phy_cmd.wr &&
            o_phy_cmd.data == $past(phy_q[15:8]))
        else $error("phy write request not issued");

    AST_PHY_CLR: assert property (
        phy_state_q == PHY_SEND && i_phy_ack && !o_phy_cmd.wr &&
        !wr_phy |=> !phy_q[PHY_RD_BIT] && !o_phy_req)
        else $error("read request bit not cleared once sent");

    AST_REPLY: assert property (
        i_phy_reply_valid |=> o_phy_reply_irq &&
            phy_q[31:24] == $past(i_phy_reply.data) &&
            phy_q[23:20] == $past(i_phy_reply.addr))
        else $error("phy reply not captured");

    AST_FULL_DROP: assert property (
        full && wr_queue |-> !ram_we || ram_test_q)
        else $error("write accepted into full queue");

    AST_EMPTY: assert property (
        empty |-> !fetch && wr_ptr_q == rd_ptr_q)
        else $error("fetch from empty queue");

    AST_TAGERR: assert property (
        ram_cmp_q && ram_rdata[QW-1] != tag_q |=> tagerr_q)
        else $error("tag mismatch not flagged");

    AST_PCLR: assert property (
        ram_acc && pclr_q && !wr_stat |=>
            !pclr_q && ptr_q == 9'h001)
        else $error("pointer clear did not restart at zero");

    AST_PTR: assert property (
        ram_acc && !pclr_q |=> ptr_q == 9'($past(ptr_q) + 9'h001))
        else $error("ram test pointer did not step");
endmodule

/* File: lnk_phy_model.sv */
`timescale 1ns/100ps
module lnk_phy_model
    import lnk_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_phy_req,
    input wire lnk_phy_req_t i_phy_cmd,
    input wire logic [2:0] i_delay,
    output logic o_phy_ack,
    output logic o_phy_reply_valid,
    output lnk_phy_reply_t o_phy_reply
);
    logic [7:0] regs [16];
    int wait_n;
    int reply_in;
    lnk_phy_reply_t last;

    initial begin
        o_phy_ack = 1'b0;
        o_phy_reply_valid = 1'b0;
        o_phy_reply = '0;
        wait_n = 0;
        reply_in = 0;
        last = '0;
        foreach (regs[i]) regs[i] = 8'h00;
    end

    // ack after a programmable stall; a read answers a few cycles later
    always @(negedge i_mclk) begin
        logic ack;
        ack = 1'b0;
        if (reply_in > 0) reply_in--;
        if (i_rst) begin
            wait_n = 0;
            reply_in = 0;
        end else if (i_phy_req === 1'b1 && o_phy_ack !== 1'b1) begin
            if (wait_n >= int'(i_delay)) begin
                ack = 1'b1;
                wait_n = 0;
                if (i_phy_cmd.wr) begin
                    regs[i_phy_cmd.addr] = i_phy_cmd.data;
                end else begin
                    last = '{addr: i_phy_cmd.addr, data: regs[i_phy_cmd.addr]};
                    reply_in = 3;
                end
            end else begin
                wait_n++;
            end
        end
        o_phy_ack = ack;
        o_phy_reply_valid = (reply_in == 1);
        // idle reply lines show junk, never the last value
        o_phy_reply = (reply_in == 1) ? last : ~last;
    end
endmodule

/* File: lnk_diag_regs_tb.sv */
`timescale 1ns/100ps
module lnk_diag_regs_tb
    import lnk_pkg::*;
;
    logic i_mclk, i_rst, rvalid, snoop, phy_req, phy_ack, rep_valid, irq;
    logic tx_take, tx_valid, take_en;
    logic [31:0] rdata, r32, d0, d1;
    logic [QW-1:0] tx_word;
    logic [7:0] v;
    logic [3:0] a;
    logic [2:0] delay;
    lnk_host_req_t host;
    lnk_phy_req_t phy_cmd;
    lnk_phy_reply_t reply;
    integer seed = 32'ha849;
    int fails = 0;
    int tests_run = 0;
    int irq_seen = 0;
    int irq_exp = 0;
    logic [63:0] exp_rd [$];
    logic [QW-1:0] exp_tx [$];
    logic [12:0] exp_phy [$];

    lnk_diag_regs i_lnk_diag_regs (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_host(host), .o_rvalid(rvalid), .o_rdata(rdata),
        .o_snoop_enable(snoop), .o_phy_req(phy_req), .o_phy_cmd(phy_cmd),
        .i_phy_ack(phy_ack), .i_phy_reply_valid(rep_valid),
        .i_phy_reply(reply), .o_phy_reply_irq(irq), .i_tx_take(tx_take),
        .o_tx_valid(tx_valid), .o_tx_word(tx_word));
    lnk_phy_model i_lnk_phy_model (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_phy_req(phy_req), .i_phy_cmd(phy_cmd), .i_delay(delay),
        .o_phy_ack(phy_ack), .o_phy_reply_valid(rep_valid),
        .o_phy_reply(reply));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    task automatic finish_test;
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic compare(input string what, input logic [QW-1:0] exp,
                           input logic [QW-1:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic op(input logic r, input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
        @(negedge i_mclk);
        host = '{rd: r, wr: w, addr: ad, wdata: d};
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        op(1'b0, 1'b1, ad, d);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] e,
                      input logic [31:0] m);
        exp_rd.push_back({m, e & m});
        op(1'b1, 1'b0, ad, 32'h0);
    endtask

    task automatic idle(input int n);
        repeat (n) op(1'b0, 1'b0, 8'h00, 32'h0);
    endtask

    // bounded wait until every noted result has shown up
    task automatic drain(input int bound);
        int n;
        n = 0;
        while ((exp_rd.size() + exp_tx.size() + exp_phy.size() > 0 ||
                irq_seen != irq_exp) && n < bound) begin
            idle(1);
            n++;
        end
        if (n >= bound) begin
            fails++;
            $display("ERROR drain expected 0 left seen %0d", exp_tx.size());
            finish_test();
        end
    endtask

    // monitors sample at the rising edge, before the design's updates land
    always @(posedge i_mclk) begin
        logic [63:0] e;
        if (!i_rst && rvalid === 1'b1) begin
            if (exp_rd.size() == 0) begin
                compare("read count", 33'h0, 33'h1);
            end else begin
                e = exp_rd.pop_front();
                compare("read data", {1'b0, e[31:0]},
                        {1'b0, rdata & e[63:32]});
            end
        end
        if (!i_rst && phy_req === 1'b1 && phy_ack === 1'b1) begin
            if (exp_phy.size() == 0) compare("phy count", 33'h0, 33'h1);
            else compare("phy cmd", {20'h0, exp_phy.pop_front()},
                         {20'h0, phy_cmd});
        end
        if (!i_rst && tx_valid === 1'b1 && tx_take === 1'b1) begin
            if (exp_tx.size() == 0) compare("tx count", 33'h0, 33'h1);
            else compare("tx word", exp_tx.pop_front(), tx_word);
        end
        if (!i_rst && irq === 1'b1) irq_seen++;
    end

    // consumer stalls at random while enabled
    always @(negedge i_mclk) tx_take <= take_en && (($random(seed) & 1) != 0);

    initial begin
        #500000;
        fails++;
        $display("ERROR watchdog expected finish seen timeout");
        finish_test();
    end

    initial begin
        host = '0;
        i_rst = 1'b1;
        delay = 3'h0;
        take_en = 1'b0;
        repeat (16) @(negedge i_mclk);
        i_rst = 1'b0;
        rd(OFF_DIAG, DIAG_RST, '1);
        rd(OFF_PHY, PHY_RST, '1);
        // empty flag and 256 free words after reset
        rd(OFF_TXQ_STAT, 32'h8000_0002, '1);
        rd(8'h10, 32'h0, '1);
        rd(OFF_RAM_WIN, 32'h0, '1);
        wr(OFF_DIAG, 32'hffff_ffef);
        rd(OFF_DIAG, 32'h1, '1);
        compare("snoop", 33'h1, {32'h0, snoop});
        wr(OFF_DIAG, 32'hffff_fffe);
        rd(OFF_DIAG, 32'h10, '1);
        wr(OFF_DIAG, 32'hffff_fffe);
        rd(OFF_DIAG, 32'hffff_fffe, '1);
        compare("snoop", 33'h0, {32'h0, snoop});
        wr(OFF_DIAG, 32'h0);
        wr(OFF_DIAG, 32'hffff_ffee);
        rd(OFF_DIAG, 32'h0, '1);
        // prompt and slow phy side
        for (int k = 0; k < 2; k++) begin
            delay = (k == 0) ? 3'h0 : 3'h5;
            r32 = $random(seed);
            v = r32[7:0];
            a = r32[11:8];
            exp_phy.push_back({1'b1, a, v});
            wr(OFF_PHY, {16'h0, v, a, 4'h2});
            drain(50);
            exp_phy.push_back({1'b0, a, 8'h00});
            irq_exp++;
            wr(OFF_PHY, {24'h0, a, 4'h1});
            drain(50);
            rd(OFF_PHY, {v, a, 4'h0, 8'h00, a, 4'h0}, '1);
        end
        wr(OFF_PHY, 32'h000f_000c);
        rd(OFF_PHY, 32'h0, '1);
        // head register plus 256 stored words, the rest dropped
        for (int i = 0; i < 260; i++) begin
            r32 = $random(seed);
            if (i < 257) exp_tx.push_back({i % 5 == 0, r32});
            wr((i % 5 == 0) ? OFF_TXQ_FIRST : OFF_TXQ_NEXT, r32);
        end
        rd(OFF_TXQ_STAT, 32'h1, 32'h3);
        take_en = 1'b1;
        drain(3000);
        take_en = 1'b0;
        idle(4);
        rd(OFF_TXQ_STAT, 32'h8000_0002, '1);
        d0 = $random(seed);
        d1 = $random(seed);
        wr(OFF_TXQ_STAT, 32'h38);
        wr(OFF_RAM_WIN, d0);
        wr(OFF_TXQ_STAT, 32'h20);
        wr(OFF_RAM_WIN, d1);
        wr(OFF_TXQ_FIRST, 32'h5);
        idle(6);
        wr(OFF_TXQ_STAT, 32'h38);
        rd(OFF_RAM_WIN, d0, '1);
        rd(OFF_RAM_WIN, d1, '1);
        idle(4);
        rd(OFF_TXQ_STAT, 32'hb4, 32'h7ffc);
        wr(OFF_TXQ_STAT, 32'h38);
        rd(OFF_RAM_WIN, d0, '1);
        idle(4);
        rd(OFF_TXQ_STAT, 32'h70, 32'h7ffc);
        rd(OFF_RAM_WIN, d1, '1);
        idle(4);
        wr(OFF_TXQ_STAT, 32'h10);
        // queue write made during the test must have been dropped
        rd(OFF_TXQ_STAT, 32'h12, 32'h3f);
        rd(OFF_RAM_WIN, 32'h0, '1);
        drain(50);
        compare("reply irqs", 33'(irq_exp), 33'(irq_seen));
        finish_test();
    end
endmodule
